/* File: core/reset_and_watchdog_control.sv */
/*
  Reset and watchdog controller: merges pin, power-on, low supply,
  watchdog, illegal fetch and disabled-stop sources into one internal reset.
  Assumes all inputs synchronous to clk; pin is open drain, resolved outside.
*/
// Added by the designer: the strobed register port.
`timescale 1ns/1ns

// Function
// RL1: Low reset pin asserts internal reset of processor and peripherals.
// RL2: Reset sequence starts on first clock edge after pin returns high.
// RL3: Internal sources drive pin low for reset length or four cycles, longer.
// RL4: Pin-originated reset drives own pulldown only three to four cycles.
// RL5: Power-up holds reset 4064 bus clocks after oscillator starts.
// RL6: Other active source at end of delay keeps reset asserted.
// RL7: Low supply asserts reset, pulldown, released after power-on delay.
// RL8: Fixed option can disable low supply reset entirely.
// RL9: Low supply reset works in stop and wait; any reset exits them.
// RL10: Watchdog timeout without clearing causes reset with pulldown.
// RL11: Fixed option enables or disables watchdog reset.
// RL12: Writing zero to bit 0 of watchdog location clears the counter.
// RL13: Reads of watchdog location return stored vector byte.
// RL14: Watchdog keeps counting in wait mode.
// RL15: Stop entry clears watchdog; held clear during reset startup delay.
// RL16: Interrupt stop exit keeps watchdog counting through startup delay.
// RL17: Fetch from unimplemented or I/O ranges causes reset with pulldown.
// RL18: Stop with stop disabled causes reset with pulldown.
// RL19: Integrator should disable stop whenever watchdog is enabled.
// RL20: Stop exit waits 4064 cycles for oscillator stabilization; a pin reset exit from stop goes straight to run without the delay.
// RL21: Watchdog timeout length is a build-time parameter.
module reset_and_watchdog_control #(
  // RL21: timeout parameter
  parameter logic [rst_ctrl_pkg::WDOG_W-1:0] WDOG_TIMEOUT = rst_ctrl_pkg::WDOG_TIMEOUT_DEF,
  parameter logic [11:0] STAB_LAST    = rst_ctrl_pkg::STAB_LAST,
  parameter logic [7:0]  VEC_BYTE     = rst_ctrl_pkg::VEC_BYTE_RST
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic                   reset_pin_in,
  output logic                        reset_pin_oe,
  output logic                        reset_pin_out,
  input  wire logic                   osc_active,
  input  wire logic                   low_supply,
  input  wire rst_ctrl_pkg::options_t opts,
  input  wire logic                   fetch_valid,
  input  wire logic [15:0]            fetch_addr,
  input  wire logic                   stop_exec,
  input  wire logic                   wait_mode,
  input  wire logic                   stop_wake_irq,
  input  wire rst_ctrl_pkg::bus_req_t bus,
  output logic [7:0]                  rdata,
  output logic                        int_rst,
  output logic                        stop_mode,
  output logic                        clk_run,
  output logic [2:0]                  cause
);

  function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic illegal_fetch(input logic [15:0] a);
    return in_rng(a, rst_ctrl_pkg::IO_LO, rst_ctrl_pkg::IO_HI) ||
           in_rng(a, rst_ctrl_pkg::HOLE1_LO, rst_ctrl_pkg::HOLE1_HI) ||
           in_rng(a, rst_ctrl_pkg::HOLE2_LO, rst_ctrl_pkg::HOLE2_HI);
  endfunction

  rst_ctrl_pkg::seq_state_t  state_q;
  logic [11:0]               stab_q;
  logic [2:0]                pull_q;
  logic [rst_ctrl_pkg::WDOG_W-1:0] wdog_q;
  logic                      wdog_hold_q;
  logic                      por_done_q;
  logic                      pin_low_q;
  logic                      lvr_seen_q;
  logic                      wdog_fire;
  logic                      ill_fire;
  logic                      stop_rst;
  logic                      lvr_act;
  logic                      int_src;
  logic                      any_src;
  logic                      wdog_clear;
  logic                      stop_enter;

  // RL8: option gates low supply
  assign lvr_act    = opts.low_supply_en && low_supply;
  // RL10: timeout fires reset
  // RL11: option gates watchdog
  assign wdog_fire  = opts.wdog_en && (wdog_q >= WDOG_TIMEOUT) && !stop_mode;
  // RL17: illegal fetch decode
  assign ill_fire   = fetch_valid && illegal_fetch(fetch_addr) && state_q == rst_ctrl_pkg::ST_RUN;
  // RL18: disabled stop becomes reset
  assign stop_rst   = stop_exec && !opts.stop_en && state_q == rst_ctrl_pkg::ST_RUN;
  assign stop_enter = stop_exec && opts.stop_en && state_q == rst_ctrl_pkg::ST_RUN;
  assign int_src    = lvr_act || wdog_fire || ill_fire || stop_rst;
  assign any_src    = int_src || !reset_pin_in;
  // RL12: zero written to clear bit
  assign wdog_clear = bus.wr && bus.addr == rst_ctrl_pkg::WDOG_ADDR &&
                      !bus.wdata[rst_ctrl_pkg::WDOG_CLR_BIT];

  // Sequencer state
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q    <= rst_ctrl_pkg::ST_HOLD;
      stab_q     <= 12'h000;
      por_done_q <= 1'b0;
      wdog_hold_q <= 1'b1;
      lvr_seen_q <= 1'b0;
    end else begin
      // Remembers a low supply so its release runs the full startup delay
      if (lvr_act) begin
        lvr_seen_q <= 1'b1;
      end
      case (state_q)
        rst_ctrl_pkg::ST_RUN: begin
          // RL1: any source enters reset
          if (any_src) begin
            state_q     <= rst_ctrl_pkg::ST_HOLD;
            wdog_hold_q <= 1'b1;
          end else if (stop_enter) begin
            state_q <= rst_ctrl_pkg::ST_STOP;
          end
        end
        rst_ctrl_pkg::ST_HOLD: begin
          stab_q <= 12'h000;
          // RL2: release starts next edge
          // RL7: low supply restarts delay
          if (!any_src && (osc_active || por_done_q)) begin
            state_q <= lvr_seen_q || !por_done_q ? rst_ctrl_pkg::ST_STAB : rst_ctrl_pkg::ST_RUN;
            wdog_hold_q <= lvr_seen_q || !por_done_q;
          end
        end
        rst_ctrl_pkg::ST_STAB: begin
          stab_q <= stab_q + 12'h001;
          // RL9: any reset aborts startup
          if (any_src) begin
            state_q     <= rst_ctrl_pkg::ST_HOLD;
            wdog_hold_q <= 1'b1;
          // RL5: 4064 cycle delay
          // RL20: stop wake delay
          end else if (stab_q == STAB_LAST) begin
            state_q     <= rst_ctrl_pkg::ST_RUN;
            por_done_q  <= 1'b1;
            wdog_hold_q <= 1'b0;
            lvr_seen_q  <= 1'b0;
          end
        end
        rst_ctrl_pkg::ST_STOP: begin
          stab_q <= 12'h000;
          // RL9: reset exits stop
          if (any_src) begin
            state_q     <= rst_ctrl_pkg::ST_HOLD;
            wdog_hold_q <= 1'b1;
          end else if (stop_wake_irq) begin
            state_q     <= rst_ctrl_pkg::ST_STAB;
            wdog_hold_q <= 1'b0;
          end
        end
        default: begin
          state_q <= rst_ctrl_pkg::ST_HOLD;
        end
      endcase
    end
  end

  // RL6: reset held while sources remain
  always_ff @(posedge clk) begin
    if (srst) begin
      int_rst <= 1'b1;
    end else begin
      // Interrupt wake from stop runs the delay without resetting the core
      int_rst <= state_q == rst_ctrl_pkg::ST_HOLD ||
                 (state_q == rst_ctrl_pkg::ST_STAB && wdog_hold_q) || any_src;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stop_mode <= 1'b0;
      clk_run   <= 1'b0;
    end else begin
      stop_mode <= state_q == rst_ctrl_pkg::ST_STOP;
      clk_run   <= state_q == rst_ctrl_pkg::ST_RUN && !any_src && !stop_enter;
    end
  end

  // Watchdog counter
  always_ff @(posedge clk) begin
    if (srst) begin
      wdog_q <= '0;
    // RL15: cleared on stop entry, held in reset
    end else if (stop_enter || wdog_hold_q || state_q == rst_ctrl_pkg::ST_HOLD ||
                 wdog_fire || wdog_clear) begin
      wdog_q <= '0;
    // RL14: counts in wait
    // RL16: counts during interrupt wake
    end else if (state_q != rst_ctrl_pkg::ST_STOP) begin
      wdog_q <= wdog_q + 1'b1;
    end
  end

  // Pin pulldown: four cycles minimum for internal sources, three for pin reset, longer while internal source active
  always_ff @(posedge clk) begin
    if (srst) begin
      pull_q    <= rst_ctrl_pkg::PULL_MIN_CYC;
      pin_low_q <= 1'b1;
    end else begin
      pin_low_q <= !reset_pin_in;
      // RL3: internal sources stretch pulldown
      if (int_src) begin
        pull_q <= rst_ctrl_pkg::PULL_MIN_CYC;
      // RL4: pin reset fires short pulse
      end else if (!reset_pin_in && !pin_low_q && pull_q == 3'h0) begin
        pull_q <= rst_ctrl_pkg::PULL_MIN_CYC;
      end else if (pull_q != 3'h0) begin
        pull_q <= pull_q - 3'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      reset_pin_oe <= 1'b1;
    end else begin
      reset_pin_oe <= int_src || (pull_q > 3'h1);
    end
  end

  always_ff @(posedge clk) begin
    reset_pin_out <= 1'b0;
  end

  // RL13: read returns vector byte
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata <= 8'h00;
    end else if (bus.rd && bus.addr == rst_ctrl_pkg::WDOG_ADDR) begin
      rdata <= VEC_BYTE;
    end else begin
      rdata <= 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cause <= 3'h0;
    end else if (int_src) begin
      cause <= {wdog_fire, ill_fire || stop_rst, lvr_act};
    end
  end

  // RL10: watchdog timeout resets with pulldown
  a_wdog_fire_rst: assert property (@(posedge clk) disable iff (srst)
    wdog_fire |=> int_rst && reset_pin_oe) else $error("watchdog timeout no reset"); // RL10
  a_ill_fetch_rst: assert property (@(posedge clk) disable iff (srst)
    ill_fire |=> int_rst && reset_pin_oe) else $error("illegal fetch no reset"); // RL17
  a_stop_dis_rst: assert property (@(posedge clk) disable iff (srst)
    stop_rst |=> int_rst ##0 reset_pin_oe) else $error("disabled stop no reset"); // RL18
  a_pin_low_rst: assert property (@(posedge clk) disable iff (srst)
    !reset_pin_in |=> int_rst) else $error("pin low without reset"); // RL1
  a_lvr_off_gate: assert property (@(posedge clk) disable iff (srst)
    !opts.low_supply_en && !int_src |-> !lvr_act) else $error("low supply not gated"); // RL8
  a_wdog_clr_zero: assert property (@(posedge clk) disable iff (srst)
    wdog_clear |=> wdog_q == '0) else $error("watchdog not cleared"); // RL12
  a_rd_vec_byte: assert property (@(posedge clk) disable iff (srst)
    bus.rd && bus.addr == rst_ctrl_pkg::WDOG_ADDR |=> rdata == VEC_BYTE)
    else $error("read not vector byte"); // RL13
  a_stop_wdog_clr: assert property (@(posedge clk) disable iff (srst)
    stop_enter |=> wdog_q == '0 && stop_mode == 1'b0 ##1 stop_mode)
    else $error("stop entry wrong"); // RL15
  a_stab_hold_rst: assert property (@(posedge clk) disable iff (srst)
    state_q == rst_ctrl_pkg::ST_STAB && stab_q == 12'h000 && wdog_hold_q |=> int_rst [*8])
    else $error("startup delay released early"); // RL5

  c_pin_reset: cover property (@(posedge clk) !reset_pin_in ##1 reset_pin_in);
  c_wdog_timeout: cover property (@(posedge clk) wdog_fire);
  c_stop_irq_wake: cover property (@(posedge clk) stop_mode ##1 stop_wake_irq);
  c_por_done: cover property (@(posedge clk) $rose(por_done_q));
  c_wait_count: cover property (@(posedge clk) wait_mode && wdog_q != '0);

  // RL13: other reads give zero
  a_rd_other_zero: assert property (@(posedge clk) disable iff (srst) // RL13
    bus.rd && bus.addr != rst_ctrl_pkg::WDOG_ADDR |=> rdata == 8'h00)
    else $error("read elsewhere not zero");

  // RL13: idle read data zero
  a_rd_idle_zero: assert property (@(posedge clk) disable iff (srst) // RL13
    !bus.rd |=> rdata == 8'h00)
    else $error("read data without read");

  // RL3: pin never driven high
  a_pin_out_low: assert property (@(posedge clk) disable iff (srst) // RL3
    1'b1 |=> reset_pin_out == 1'b0)
    else $error("pin driven high");

  // RL3: internal source pulls pin
  a_int_src_pull: assert property (@(posedge clk) disable iff (srst) // RL3
    int_src |=> reset_pin_oe)
    else $error("internal source without pulldown");

  // RL4: pulldown ends with count
  a_pull_ends: assert property (@(posedge clk) disable iff (srst) // RL4
    pull_q == 3'h0 && !int_src |=> !reset_pin_oe)
    else $error("pulldown too long");

  // RL4: count never above minimum
  a_pull_bound: assert property (@(posedge clk) disable iff (srst) // RL4
    pull_q <= rst_ctrl_pkg::PULL_MIN_CYC)
    else $error("pulldown count out of range");

  // RL7: low supply resets with pulldown
  a_lvr_rst_pull: assert property (@(posedge clk) disable iff (srst) // RL7
    lvr_act |=> int_rst && reset_pin_oe)
    else $error("low supply no reset");

  // RL7: low supply keeps hold state
  a_lvr_keep_hold: assert property (@(posedge clk) disable iff (srst) // RL7
    state_q == rst_ctrl_pkg::ST_HOLD && lvr_act |=> state_q == rst_ctrl_pkg::ST_HOLD)
    else $error("low supply hold left");

  // RL11: disabled watchdog never causes
  a_wdog_off_cause: assert property (@(posedge clk) disable iff (srst) // RL11
    !opts.wdog_en |=> !cause[2])
    else $error("disabled watchdog caused reset");

  // RL10: timeout clears counter
  a_wdog_tmo_clr: assert property (@(posedge clk) disable iff (srst) // RL10
    opts.wdog_en && wdog_q >= WDOG_TIMEOUT && !stop_mode |=> wdog_q == '0)
    else $error("timeout not cleared");

  // RL14: counts while running in wait mode
  a_wdog_run_cnt: assert property (@(posedge clk) disable iff (srst) // RL14
    state_q == rst_ctrl_pkg::ST_RUN && wait_mode && !wdog_hold_q && !wdog_fire &&
    !wdog_clear && !stop_enter |=> wdog_q == $past(wdog_q) + 1)
    else $error("watchdog stalled in wait");

  // RL15: counter zero in stop
  a_stop_wdog_zero: assert property (@(posedge clk) disable iff (srst) // RL15
    state_q == rst_ctrl_pkg::ST_STOP |-> wdog_q == '0)
    else $error("watchdog counts in stop");

  // RL15: held clear in reset startup
  a_rst_wake_hold: assert property (@(posedge clk) disable iff (srst) // RL15
    state_q == rst_ctrl_pkg::ST_STAB && wdog_hold_q |-> wdog_q == '0)
    else $error("watchdog counts in reset startup");

  // RL16: counts during interrupt wake
  a_irq_wake_cnt: assert property (@(posedge clk) disable iff (srst) // RL16
    state_q == rst_ctrl_pkg::ST_STAB && !wdog_hold_q && !wdog_fire && !wdog_clear
    |=> wdog_q == $past(wdog_q) + 1)
    else $error("watchdog stalled in wake");

  // RL16: interrupt wake keeps core out of reset
  a_irq_wake_norst: assert property (@(posedge clk) disable iff (srst) // RL16
    state_q == rst_ctrl_pkg::ST_STAB && !wdog_hold_q && !any_src |=> !int_rst)
    else $error("interrupt wake reset core");

  // RL5: delay end releases
  a_stab_end_run: assert property (@(posedge clk) disable iff (srst) // RL5
    state_q == rst_ctrl_pkg::ST_STAB && stab_q == STAB_LAST && !any_src
    |=> state_q == rst_ctrl_pkg::ST_RUN)
    else $error("startup delay end missed");

  // RL5: first release runs delay
  a_por_to_stab: assert property (@(posedge clk) disable iff (srst) // RL5
    state_q == rst_ctrl_pkg::ST_HOLD && !por_done_q && !any_src && osc_active
    |=> state_q == rst_ctrl_pkg::ST_STAB)
    else $error("power-on delay skipped");

  // RL9: reset leaves stop
  a_stop_exit_rst: assert property (@(posedge clk) disable iff (srst) // RL9
    state_q == rst_ctrl_pkg::ST_STOP && any_src |=> state_q == rst_ctrl_pkg::ST_HOLD)
    else $error("reset did not leave stop");

  // RL20: interrupt wake starts delay
  a_stop_irq_stab: assert property (@(posedge clk) disable iff (srst) // RL20
    state_q == rst_ctrl_pkg::ST_STOP && !any_src && stop_wake_irq
    |=> state_q == rst_ctrl_pkg::ST_STAB)
    else $error("wake did not start delay");

  // RL2: pin release resumes next edge
  a_pin_rel_run: assert property (@(posedge clk) disable iff (srst) // RL2
    state_q == rst_ctrl_pkg::ST_HOLD && !any_src && por_done_q && !lvr_seen_q
    |=> state_q == rst_ctrl_pkg::ST_RUN)
    else $error("pin release late");

  // RL6: reset held while source active
  a_src_hold_rst: assert property (@(posedge clk) disable iff (srst) // RL6
    any_src |=> int_rst)
    else $error("reset dropped with source active");

  // RL17: illegal fetch cause code
  a_ill_cause: assert property (@(posedge clk) disable iff (srst) // RL17
    ill_fire && !wdog_fire && !lvr_act |=> cause == 3'b010)
    else $error("illegal fetch cause wrong");

  // RL1: core never runs in reset
  a_rst_no_run: assert property (@(posedge clk) disable iff (srst) // RL1
    int_rst |-> !clk_run)
    else $error("core runs during reset");

endmodule // reset_and_watchdog_control

/* File: core/rst_ctrl_pkg.sv */
/*
  Package for the reset and watchdog controller: register address, field
  positions, timing counts and shared types.
  Assumes a single 250 MHz processor bus clock.
*/
package rst_ctrl_pkg;

  localparam int unsigned CLK_MHZ         = 250;
  localparam int unsigned STAB_CYCLES     = 4064;
  localparam logic [11:0] STAB_LAST       = 12'(STAB_CYCLES - 1);
  localparam logic [2:0]  PULL_MIN_CYC    = 3'h4;
  localparam logic [15:0] WDOG_ADDR       = 16'h3ff0;
  localparam int unsigned WDOG_CLR_BIT    = 0;
  localparam logic [7:0]  VEC_BYTE_RST    = 8'h00;
  localparam logic [15:0] IO_LO           = 16'h0000;
  localparam logic [15:0] IO_HI           = 16'h003f;
  localparam logic [15:0] HOLE1_LO        = 16'h01c0;
  localparam logic [15:0] HOLE1_HI        = 16'h023f;
  localparam logic [15:0] HOLE2_LO        = 16'h0340;
  localparam logic [15:0] HOLE2_HI        = 16'h0cff;
  localparam int unsigned WDOG_W          = 20;
  localparam logic [WDOG_W-1:0] WDOG_TIMEOUT_DEF = 20'h3ffff;

  typedef enum logic [3:0] {
    ST_RUN   = 4'b0001,
    ST_HOLD  = 4'b0010,
    ST_STAB  = 4'b0100,
    ST_STOP  = 4'b1000
  } seq_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } bus_req_t;

  typedef struct packed {
    logic wdog_en;
    logic stop_en;
    logic low_supply_en;
  } options_t;

endpackage

/* File: sim/pin_partner.sv */
/*
  Reset pin far side: external reset driver and pull-up on the open-drain pin.
  Assumes the device pulls low only while its output enable is high.
*/
`timescale 1ns/1ns
module pin_partner (
  input  wire logic ext_low,
  input  wire logic dev_oe,
  input  wire logic dev_out,
  output logic      pin
);
  assign pin = (ext_low | (dev_oe & ~dev_out)) ? 1'b0 : 1'b1;
endmodule // pin_partner

/* File: sim/testbench.sv */
/*
  Testbench for the reset and watchdog controller: task-driven scenarios.
  Assumes short startup and watchdog counts set through parameters.
*/
`timescale 1ns/1ns
module testbench;
  localparam logic [11:0] STAB = 12'h00f;
  localparam logic [19:0] WDT  = 20'h00040;
  localparam logic [7:0]  VEC  = 8'h5a;
  logic clk = 1'b0, srst = 1'b1, ext_low = 1'b0, osc = 1'b1, low_sup = 1'b0;
  logic fv = 1'b0, stp = 1'b0, wt = 1'b0, irq = 1'b0;
  logic pin, oe, pout, irst, smode, crun;
  logic [15:0]            fa = 16'h0000;
  logic [7:0]             rdata;
  logic [2:0]             cause;
  rst_ctrl_pkg::options_t opts = '0;
  rst_ctrl_pkg::bus_req_t bus = '0;
  int failures = 0, cmp_count = 0, cyc = 0, n = 0;
  logic [15:0] adr [10] = '{16'h0000, 16'h003f, 16'h01c0, 16'h023f, 16'h0340,
                            16'h0cff, 16'h0040, 16'h01bf, 16'h0240, 16'h0d00};
  always #2 clk = ~clk;
  pin_partner u_pin (.ext_low(ext_low), .dev_oe(oe), .dev_out(pout), .pin(pin));
  reset_and_watchdog_control #(.WDOG_TIMEOUT(WDT), .STAB_LAST(STAB), .VEC_BYTE(VEC)) u_dut (
    .clk(clk), .srst(srst), .reset_pin_in(pin), .reset_pin_oe(oe), .reset_pin_out(pout),
    .osc_active(osc), .low_supply(low_sup), .opts(opts), .fetch_valid(fv),
    .fetch_addr(fa), .stop_exec(stp), .wait_mode(wt), .stop_wake_irq(irq), .bus(bus),
    .rdata(rdata), .int_rst(irst), .stop_mode(smode), .clk_run(crun), .cause(cause));
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic wait_rst(input logic v, input int mx);
    n = 0;
    while (irst !== v && n < mx) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic boot(input logic [2:0] o);
    @(posedge clk) srst <= 1'b1;
    opts <= rst_ctrl_pkg::options_t'(o);
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(negedge clk);
    wait_rst(1'b0, 60);
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    @(negedge clk) chk(rdata, exp);
  endtask
  task automatic pulse(input logic is_stop, input logic [15:0] a);
    @(posedge clk) fv <= ~is_stop;
    stp <= is_stop;
    fa <= a;
    @(posedge clk) fv <= 1'b0;
    stp <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic count_oe(input int len);
    n = 0;
    repeat (len) begin
      @(negedge clk);
      n += int'(oe === 1'b1);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    boot(3'b000);
    chk(n >= 16 && n <= 22, 1'b1);
    rd(rst_ctrl_pkg::WDOG_ADDR, VEC);
    rd(16'h3ff1, 8'h00);
    repeat (100) @(negedge clk);
    chk(irst, 1'b0);
    for (int i = 0; i < 10; i++) begin
      pulse(1'b0, adr[i]);
      chk({irst, oe}, {2{i < 6}});
      if (i < 6) chk(cause, 3'b010);
      wait_rst(1'b0, 40);
    end
    pulse(1'b1, 16'h0000);
    chk({irst, cause}, 4'b1010);
    $display("fetch and stop reset test done");
    boot(3'b010);
    @(posedge clk) low_sup <= 1'b1;
    repeat (6) @(negedge clk);
    chk(irst, 1'b0);
    @(posedge clk) low_sup <= 1'b0;
    pulse(1'b1, 16'h0000);
    chk({smode, irst}, 2'b10);
    @(posedge clk) irq <= 1'b1;
    @(posedge clk) irq <= 1'b0;
    repeat (2) @(negedge clk);
    chk(irst, 1'b0);
    n = 0;
    while (crun !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk(n >= 15 && n < 40 && smode === 1'b0, 1'b1);
    boot(3'b011);
    pulse(1'b1, 16'h0000);
    @(posedge clk) low_sup <= 1'b1;
    repeat (3) @(negedge clk);
    chk({irst, oe, smode, cause}, 6'b110001);
    @(posedge clk) low_sup <= 1'b0;
    wait_rst(1'b0, 60);
    chk(n >= 15 && n < 60, 1'b1);
    $display("stop and low supply test done");
    boot(3'b100);
    wt <= 1'b1;
    repeat (4) begin
      repeat (40) @(posedge clk);
      wr(rst_ctrl_pkg::WDOG_ADDR, 8'hfe);
    end
    chk(irst, 1'b0);
    wr(rst_ctrl_pkg::WDOG_ADDR, 8'h01);
    wait_rst(1'b1, 80);
    chk(n >= 50 && n < 70 && cause === 3'b100, 1'b1);
    count_oe(3);
    chk(n, 3);
    wait_rst(1'b0, 40);
    @(posedge clk) wt <= 1'b0;
    $display("watchdog test done");
    @(posedge clk) ext_low <= 1'b1;
    repeat (2) @(negedge clk);
    chk(irst, 1'b1);
    count_oe(20);
    chk(n >= 2 && n <= 4, 1'b1);
    @(posedge clk) ext_low <= 1'b0;
    @(negedge clk);
    wait_rst(1'b0, 8);
    chk(n <= 3, 1'b1);
    $display("pin reset test done");
    finish_test();
  end
endmodule // testbench
